// ### core/synth_mod_band_status_regs.v
// serial-written modulator/band configuration and sticky flags registers
//
// Summary of operation
// - code 110 loads modulator and band register
// - report read-only loop lock status
// - band search done bit, zero while searching
// - lock window from extra precision bits
// - boost bit extends output power levels
// - order 00 integer, 10 second, 11 third
// - dither one or four LSB, shaping enable
// - band search accuracy 1, 2, 4 cycles
// - band field shows band, manual write overrides
// - manual bit picks held or searched band
// - band divisor is base plus 256 times upper
// - sticky loss-of-lock, write one clears
// - sticky band-change, write one clears
// - serial error bit reads frame error
// - frame not 32 clocks sets serial error
// - code 111 loads flags register
`timescale 1ns/1ns
`include "synth_regs_map.vh"
module synth_mod_band_status_regs #(
   parameter BAND_W = 8   // VCO band width
) (
   input  wire              mclk,                 // 100 MHz system clock
   input  wire              rst_n,                // async reset, active low
   input  wire              serial_clk,           // host serial clock pin
   input  wire              serial_data,          // host serial data pin, msb first
   input  wire              chip_select_n,        // frame select pin, active low
   input  wire              lock_raw,             // lock comparator verdict
   input  wire              search_busy,          // band search in progress
   input  wire              search_event,         // pulse: auto search picked a band
   input  wire [BAND_W-1:0] search_band,          // band chosen by auto search
   input  wire [7:0]        band_clock_divider_base, // base band clock divider
   input  wire              lock_window_precision,   // precision bit held elsewhere
   input  wire [1:0]        output_power_code,    // power field held elsewhere
   output reg  [3:0]        lock_window_code,     // 0:10 1:6 2:3 3:4 4:4.5 5:1.5 ns
   output reg  [2:0]        power_level_code,     // index into eight power steps
   output reg  [1:0]        modulator_order,      // 0 off, 2 second, 3 third
   output reg               integer_mode,         // fractional value ignored
   output reg  [2:0]        dither_scale,         // dither amplitude in LSB
   output reg               dither_shaping_enable,// shaping of dither on
   output reg               modulator_type,       // modulator variant select
   output reg  [2:0]        search_accuracy_cycles, // band clock cycles per step
   output reg  [BAND_W-1:0] band_in_use,          // band driven to the VCO
   output reg  [11:0]       band_clock_divisor,   // full band clock divisor
   output reg  [31:0]       modband_readback,     // modulator/band register image
   output reg  [31:0]       flags_readback        // flags register image
);
   // pin synchronisers, first stage read only by second; bit 2 chip select,
   // bit 1 data, bit 0 serial clock
   reg [2:0] sclk_s1_q;
   reg [2:0] sclk_s2_q;
   reg       sclk_prev_q;
   // both stages reset to the idle pin levels, chip select high and clock low,
   // so release from reset never shows a false frame end or clock edge
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_s1_q <= 3'h4;
         sclk_s2_q <= 3'h4;
      end else begin
         sclk_s1_q <= {chip_select_n, serial_data, serial_clk};
         sclk_s2_q <= sclk_s1_q;
      end
   end

   // previous synchronised clock level for rise detection
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         sclk_prev_q <= 1'b0;
      else
         sclk_prev_q <= sclk_s2_q[0];
   end
   wire sclk_rise = sclk_s2_q[0] & ~sclk_prev_q;
   wire sdat      = sclk_s2_q[1];
   wire cs_n      = sclk_s2_q[2];
   reg  cs_prev_q;
   wire cs_rise   = cs_n & ~cs_prev_q;

   // shift register and clock counter; count saturates so long frames stay wrong
   // the count is held through the chip select rise so the commit sees it
   // a short or long frame therefore never reaches either register
   reg [31:0] shift_q;
   reg [5:0]  count_q;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q   <= 32'h0;
         count_q   <= 6'h0;
         cs_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_n;
         if (cs_n && !cs_prev_q) begin
            count_q <= count_q;
         end else if (cs_n) begin
            count_q <= 6'h0;
         end else if (sclk_rise) begin
            shift_q <= {shift_q[30:0], sdat};
            if (count_q != 6'h3F)
               count_q <= count_q + 6'h1;
         end
      end
   end
   // commit decision, made once per frame on the synchronised chip select rise
   wire frame_ok  = (count_q == `FRAME_BITS);
   wire frame_bad = cs_rise & ~frame_ok;
   wire [2:0] cb  = shift_q[`CB_MSB:`CB_LSB];
   wire wr_mb     = cs_rise & frame_ok & (cb == `CB_MODBAND);
   wire wr_fl     = cs_rise & frame_ok & (cb == `CB_FLAGS);

   // configuration fields of the modulator/band register
   reg [BAND_W-1:0] band_hold_q;   // band written by the host
   reg              manual_q;      // manual band enable
   reg              type_q;        // modulator variant
   reg              shape_q;       // dither shaping enable
   reg              gain_q;        // dither gain
   reg              boost_q;       // output power boost
   reg              bit7_q;        // reserved bit, kept only for readback
   reg [3:0]        upper_q;       // upper band clock divider bits
   reg [1:0]        acc_q;         // band search accuracy code
   reg [1:0]        order_q;       // modulator order code
   reg [1:0]        extp_q;        // extra lock window precision
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         band_hold_q <= {BAND_W{1'b0}};
         manual_q    <= 1'b0;
         upper_q     <= 4'h0;
         acc_q       <= 2'h0;
         type_q      <= 1'b0;
         shape_q     <= `MB_SHAPE_RST;
         gain_q      <= 1'b0;
         order_q     <= `MB_ORDER_RST;
         boost_q     <= 1'b0;
         extp_q      <= 2'h0;
         bit7_q      <= 1'b0;
      end else if (wr_mb) begin
         manual_q <= shift_q[`MB_MANUAL_BIT];
         // band written only takes hold with manual enable in the same frame
         if (shift_q[`MB_MANUAL_BIT])
            band_hold_q <= shift_q[`MB_BAND_MSB:`MB_BAND_LSB];
         upper_q  <= shift_q[`MB_UPPER_MSB:`MB_UPPER_LSB];
         acc_q    <= shift_q[`MB_ACC_MSB:`MB_ACC_LSB];
         type_q   <= shift_q[`MB_TYPE_BIT];
         shape_q  <= shift_q[`MB_SHAPE_BIT];
         gain_q   <= shift_q[`MB_GAIN_BIT];
         order_q  <= shift_q[`MB_ORDER_MSB:`MB_ORDER_LSB];
         boost_q  <= shift_q[`MB_BOOST_BIT];
         extp_q   <= shift_q[`MB_EXTP_MSB:`MB_EXTP_LSB];
         bit7_q   <= shift_q[7];
      end
   end

   // status inputs from the loop logic are on mclk already
   // busy resets high so the done bit reads zero until the search reports
   reg lock_q, lock_prev_q, busy_q;
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_q      <= 1'b0;
         lock_prev_q <= 1'b0;
         busy_q      <= 1'b1;
      end else begin
         lock_q      <= lock_raw;
         lock_prev_q <= lock_q;
         busy_q      <= search_busy;
      end
   end
   wire lock_lost = lock_prev_q & ~lock_q;

   // sticky flags; a write of one clears, an event in that cycle still sets
   wire loss_q, bandchg_q, serr_q;
   // loss of lock: falling edge of the registered lock verdict
   sticky_flag u_loss (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .set_evt (lock_lost),
      .clr_evt (wr_fl & shift_q[`FL_LOSS_BIT]),
      .flag_q  (loss_q)
   );
   // band change: one pulse per band picked by the search
   sticky_flag u_bandchg (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .set_evt (search_event),
      .clr_evt (wr_fl & shift_q[`FL_BANDCHG_BIT]),
      .flag_q  (bandchg_q)
   );
   // frame error: any frame that did not carry exactly 32 clocks
   sticky_flag u_serr (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .set_evt (frame_bad),
      .clr_evt (wr_fl & shift_q[`FL_SERR_BIT]),
      .flag_q  (serr_q)
   );

   // encodings of the decoded outputs; named so the tables below read plainly
   localparam [3:0] LW_10NS   = 4'h0;  // widest window, the reset choice
   localparam [3:0] LW_6NS    = 4'h1;  // plain precision bit set
   localparam [3:0] LW_3NS    = 4'h2;  // first extra step
   localparam [3:0] LW_4NS    = 4'h3;  // second extra step, precision low
   localparam [3:0] LW_4P5NS  = 4'h4;  // second extra step, precision high
   localparam [3:0] LW_1P5NS  = 4'h5;  // narrowest, for high detector rates
   localparam [2:0] CYC_ONE   = 3'h1;  // one band clock cycle
   localparam [2:0] CYC_TWO   = 3'h2;  // two band clock cycles
   localparam [2:0] CYC_FOUR  = 3'h4;  // four band clock cycles
   localparam [2:0] DITH_ONE  = 3'h1;  // dither at one LSB
   localparam [2:0] DITH_FOUR = 3'h4;  // dither at four LSB

   // lock window: the extra bits refine the plain precision bit
   reg [3:0] lw_d;
   always @* begin
      case ({extp_q, lock_window_precision})
         3'h0:    lw_d = LW_10NS;
         3'h1:    lw_d = LW_6NS;
         3'h2:    lw_d = LW_3NS;
         3'h3:    lw_d = LW_3NS;     // precision bit has no effect here
         3'h4:    lw_d = LW_4NS;
         3'h5:    lw_d = LW_4P5NS;
         3'h6:    lw_d = LW_1P5NS;
         3'h7:    lw_d = LW_1P5NS;   // precision bit has no effect here
         default: lw_d = LW_10NS;
      endcase
   end

   // band search accuracy in band clock cycles
   reg [2:0] acc_d;
   always @* begin
      case (acc_q)
         2'h0:    acc_d = CYC_ONE;
         2'h1:    acc_d = CYC_TWO;
         2'h2:    acc_d = CYC_FOUR;
         default: acc_d = CYC_ONE;   // reserved code falls back to one cycle
      endcase
   end

   // register images for readback, each field placed at its map position
   reg [31:0] mb_img_d;
   reg [31:0] fl_img_d;
   always @* begin
      mb_img_d                              = 32'h0;
      mb_img_d[`CB_MSB:`CB_LSB]             = `CB_MODBAND;
      mb_img_d[`MB_BAND_MSB:`MB_BAND_LSB]   = band_in_use;
      // the reserved bit shares its slot with band bit four, so both show
      mb_img_d[7]                           = mb_img_d[7] | bit7_q;
      mb_img_d[`MB_MANUAL_BIT]              = manual_q;
      mb_img_d[`MB_UPPER_MSB:`MB_UPPER_LSB] = upper_q;
      mb_img_d[`MB_ACC_MSB:`MB_ACC_LSB]     = acc_q;
      mb_img_d[`MB_TYPE_BIT]                = type_q;
      mb_img_d[`MB_SHAPE_BIT]               = shape_q;
      mb_img_d[`MB_GAIN_BIT]                = gain_q;
      mb_img_d[`MB_ORDER_MSB:`MB_ORDER_LSB] = order_q;
      mb_img_d[`MB_BOOST_BIT]               = boost_q;
      mb_img_d[`MB_EXTP_MSB:`MB_EXTP_LSB]   = extp_q;
      mb_img_d[`MB_DONE_BIT]                = ~busy_q;
      mb_img_d[`MB_LOCK_BIT]                = lock_q;
      fl_img_d                              = 32'h0;
      fl_img_d[`CB_MSB:`CB_LSB]             = `CB_FLAGS;
      fl_img_d[`FL_REV_MSB:`FL_REV_LSB]     = `REV_CODE;
      fl_img_d[`FL_PART_MSB:`FL_PART_LSB]   = `PART_CODE;
      fl_img_d[`FL_SERR_BIT]                = serr_q;
      fl_img_d[`FL_BANDCHG_BIT]             = bandchg_q;
      fl_img_d[`FL_LOSS_BIT]                = loss_q;
   end

   // loop configuration outputs, registered so the analog side sees clean edges
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lock_window_code       <= LW_10NS;
         power_level_code       <= 3'h0;
         modulator_order        <= `MB_ORDER_RST;
         integer_mode           <= 1'b0;
         dither_scale           <= DITH_ONE;
         dither_shaping_enable  <= `MB_SHAPE_RST;
         modulator_type         <= 1'b0;
      end else begin
         lock_window_code       <= lw_d;
         power_level_code       <= {boost_q, output_power_code};
         modulator_order        <= order_q;
         integer_mode           <= (order_q == 2'h0);
         dither_scale           <= gain_q ? DITH_FOUR : DITH_ONE;
         dither_shaping_enable  <= shape_q;
         modulator_type         <= type_q;
      end
   end

   // band selection outputs; the divisor is a plain join since upper counts 256s
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         search_accuracy_cycles <= CYC_ONE;
         band_in_use            <= {BAND_W{1'b0}};
         band_clock_divisor     <= 12'h0;
      end else begin
         search_accuracy_cycles <= acc_d;
         band_in_use            <= manual_q ? band_hold_q : search_band;
         band_clock_divisor     <= {upper_q, band_clock_divider_base};
      end
   end

   // readback images trail the live fields by one clock, far below a serial
   // frame time, so a host never sees the lag
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         modband_readback       <= 32'h0;
         flags_readback         <= 32'h0;
      end else begin
         modband_readback       <= mb_img_d;
         flags_readback         <= fl_img_d;
      end
   end
endmodule

// ### core/synth_regs_map.vh
// field positions, reset values and codes for the modulator/band and flags registers
`ifndef SYNTH_REGS_MAP_VH
`define SYNTH_REGS_MAP_VH
`define FRAME_BITS        6'd32
`define CB_LSB            0
`define CB_MSB            2
`define CB_MODBAND        3'h6
`define CB_FLAGS          3'h7
// modulator_band_config fields
`define MB_BAND_LSB       3
`define MB_BAND_MSB       10
`define MB_MANUAL_BIT     11
`define MB_UPPER_LSB      12
`define MB_UPPER_MSB      15
`define MB_ACC_LSB        16
`define MB_ACC_MSB        17
`define MB_TYPE_BIT       18
`define MB_SHAPE_BIT      19
`define MB_GAIN_BIT       20
`define MB_ORDER_LSB      21
`define MB_ORDER_MSB      22
`define MB_BOOST_BIT      23
`define MB_EXTP_LSB       24
`define MB_EXTP_MSB       25
`define MB_DONE_BIT       26
`define MB_LOCK_BIT       27
`define MB_ORDER_RST      2'h3
`define MB_SHAPE_RST      1'h1
// flags_ident_control fields
`define FL_REV_LSB        20
`define FL_REV_MSB        22
`define FL_PART_LSB       23
`define FL_PART_MSB       26
`define FL_SERR_BIT       27
`define FL_BANDCHG_BIT    28
`define FL_LOSS_BIT       29
`define REV_CODE          3'h5   // arbitrary identity value
`define PART_CODE         4'h9   // arbitrary identity value
`endif

// ### core/sticky_flag.v
// one sticky status bit: hardware set, write-one-to-clear, set wins
`timescale 1ns/1ns
module sticky_flag (
   input  wire mclk,    // system clock
   input  wire rst_n,   // async reset, active low
   input  wire set_evt, // hardware event pulse
   input  wire clr_evt, // clear strobe from host write of one
   output reg  flag_q   // sticky flag
);
   // set beats clear so an event in the clear cycle is kept
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         flag_q <= 1'b0;
      else if (set_evt)
         flag_q <= 1'b1;
      else if (clr_evt)
         flag_q <= 1'b0;
   end
endmodule

// ### testbench/synth_regs_checker.sv
// assertion checker for the modulator/band and flags register block
`timescale 1ns/1ns
module synth_regs_checker #(
   parameter BAND_W = 8   // band width
) (
   input logic              mclk,                    // clock
   input logic              rst_n,                   // reset
   input logic              chip_select_n,           // frame select
   input logic              lock_raw,                // lock verdict
   input logic              search_busy,             // search running
   input logic              search_event,            // band picked
   input logic [BAND_W-1:0] search_band,             // searched band
   input logic [7:0]        band_clock_divider_base, // base divider
   input logic [1:0]        output_power_code,       // power field
   input logic [2:0]        power_level_code,        // power step
   input logic [1:0]        modulator_order,         // order
   input logic              integer_mode,            // integer mode
   input logic [BAND_W-1:0] band_in_use,             // band used
   input logic [11:0]       band_clock_divisor,      // full divisor
   input logic [31:0]       modband_readback,        // config image
   input logic [31:0]       flags_readback           // flags image
);
   // one domain, so clock and reset are given once
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_INT_MODE: assert property (integer_mode == (modulator_order == 2'h0))
      else $error("integer mode does not follow order");
   AST_DIV_BASE: assert property ($past(rst_n) |->
      band_clock_divisor[7:0] == $past(band_clock_divider_base)) else $error("divisor base");
   AST_DIV_UPPER: assert property (band_clock_divisor[11:8] == modband_readback[15:12])
      else $error("divisor upper");
   AST_BAND_AUTO: assert property ($past(rst_n) && !modband_readback[11] &&
      !$past(modband_readback[11]) |-> band_in_use == $past(search_band))
      else $error("auto band");
   AST_POWER: assert property ($past(rst_n) |->
      power_level_code[1:0] == $past(output_power_code)) else $error("power level");
   // the done bit passes a status flop and then the image flop: two clocks
   AST_DONE: assert property ($past(rst_n, 2) |->
      modband_readback[26] == !$past(search_busy, 2)) else $error("search done bit");
   AST_LOSS_SET: assert property ($fell(lock_raw) |-> ##[1:3] flags_readback[29])
      else $error("loss of lock not flagged");
   AST_BANDCHG_SET: assert property (search_event |-> ##[1:3] flags_readback[28])
      else $error("band change not flagged");
   AST_SERR_HOLD: assert property (flags_readback[27] && !chip_select_n |=>
      flags_readback[27]) else $error("serial error dropped mid frame");
   AST_CODES: assert property ($past(rst_n) |-> modband_readback[2:0] == 3'h6 &&
      flags_readback[2:0] == 3'h7) else $error("control code field");
   // main scenarios
   cover property ($fell(lock_raw));
   cover property (search_event);
   cover property ($rose(flags_readback[27]));
endmodule

// ### testbench/spi_host_model.sv
// host model: drives serial write frames of n clocks from a 32-bit word, msb first
`timescale 1ns/1ns
module spi_host_model (
   input  logic mclk,          // system clock
   output logic serial_clk,    // serial clock, still outside frames
   output logic serial_data,   // data, msb first
   output logic chip_select_n  // frame select
);
   initial begin
      serial_clk = 1'b0;
      serial_data = 1'b0;
      chip_select_n = 1'b1;
   end
   // phases of four clocks keep above the three the block needs
   task automatic frame(input logic [31:0] d, input int n);
      int k;
      d[7] = 1'b0;
      @(posedge mclk) chip_select_n <= 1'b0;
      for (k = 0; k < n; k++) begin
         repeat (4) @(posedge mclk);
         serial_data <= d[(31 - k) & 31];
         repeat (4) @(posedge mclk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge mclk);
         serial_clk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      chip_select_n <= 1'b1;
      serial_data <= ~serial_data; // released line shows no stale bit
      repeat (6) @(posedge mclk);
      if (n == 32 && d[2:0] == 3'h6) frame(~d & 32'hFFFF_FFF8, 32);
   endtask
endmodule

// ### testbench/synth_mod_band_status_regs_tb.sv
// self-checking bench for the modulator/band and flags registers
`timescale 1ns/1ns
module synth_mod_band_status_regs_tb;
   logic        mclk = 1'b0, rst_n = 1'b0, serial_clk, serial_data, chip_select_n;
   logic        lock_raw = 1'b0, search_busy = 1'b1, search_event = 1'b0;
   logic        lock_window_precision = 1'b0, integer_mode, modulator_type;
   logic        dither_shaping_enable;
   logic [7:0]  search_band = 8'h00, band_clock_divider_base = 8'h5A, band_in_use;
   logic [1:0]  output_power_code = 2'h0, modulator_order;
   logic [3:0]  lock_window_code;
   logic [2:0]  power_level_code, dither_scale, search_accuracy_cycles;
   logic [11:0] band_clock_divisor;
   logic [31:0] modband_readback, flags_readback;
   int          n_mismatch = 0, total_checks = 0, cyc = 0;
   logic [3:0]  lwt [8] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h5, 4'h5};
   logic [2:0]  acct [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
   synth_mod_band_status_regs dut (.mclk, .rst_n, .serial_clk, .serial_data,
      .chip_select_n, .lock_raw, .search_busy, .search_event, .search_band,
      .band_clock_divider_base, .lock_window_precision, .output_power_code,
      .lock_window_code, .power_level_code, .modulator_order, .integer_mode,
      .dither_scale, .dither_shaping_enable, .modulator_type, .search_accuracy_cycles,
      .band_in_use, .band_clock_divisor, .modband_readback, .flags_readback);
   spi_host_model host (.mclk, .serial_clk, .serial_data, .chip_select_n);
   // clock and hang guard; the ceiling leaves ample room over about 9k cycles
   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_reset;
      chk(modulator_order, 2'h3);
      chk({dither_shaping_enable, dither_scale}, 4'h9);
      chk(search_accuracy_cycles, 3'h1);
   endtask
   // every lock window and power code once; band bit four kept clear
   task automatic t_config;
      logic [31:0] d;
      logic [1:0]  ord;
      for (int i = 0; i < 8; i++) begin
         ord = (i[1:0] == 2'h1) ? 2'h2 : (i[1:0] == 2'h2) ? 2'h3 : 2'h0;
         @(posedge mclk);
         lock_window_precision <= i[2];
         output_power_code <= i[1:0];
         band_clock_divider_base <= 8'h5A ^ i[7:0];
         d = {6'h00, i[1:0], i[2], ord, i[0], i[1], i[2], i[1:0], ~i[3:0], 1'b1,
            3'h6 ^ i[2:0], 5'h03, 3'h6};
         host.frame(d, 32);
         chk(lock_window_code, lwt[{i[1:0], i[2]}]);
         chk(power_level_code, {i[2], i[1:0]});
         chk({integer_mode, modulator_order}, {ord == 2'h0, ord});
         chk({dither_scale, dither_shaping_enable}, {i[0] ? 3'h4 : 3'h1, i[1]});
         chk(modulator_type, i[2]);
         chk(search_accuracy_cycles, acct[i[1:0]]);
         chk(band_in_use, d[10:3]);
         chk(band_clock_divisor, {~i[3:0], band_clock_divider_base});
         chk(modband_readback[25:3], d[25:3]);
      end
   endtask
   task automatic t_auto;
      host.frame(32'h0060_0006, 32);
      @(posedge mclk);
      search_band <= 8'h3C;
      search_busy <= 1'b0;
      lock_raw <= 1'b1;
      repeat (4) @(posedge mclk);
      chk(band_in_use, 8'h3C);
      chk(modband_readback[10:3], 8'h3C);
      chk(modband_readback[27:26], 2'h3);
      search_busy <= 1'b1;
      lock_raw <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(modband_readback[27:26], 2'h0);
   endtask
   // sticky flags, short and long frames, selective clearing
   task automatic t_flags;
      search_event <= 1'b1;
      @(posedge mclk) search_event <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(flags_readback[29:27], 3'h6);
      host.frame(32'h0000_0006, 31);
      chk(flags_readback[29:27], 3'h7);
      host.frame(32'h0000_0006, 33);
      chk(modulator_order, 2'h3);
      host.frame(32'h1000_0007, 32);
      chk(flags_readback[29:27], 3'h5);
      host.frame(32'h2800_0007, 32);
      chk(flags_readback[29:27], 3'h0);
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_reset();
      t_config();
      t_auto();
      t_flags();
      complete_run();
   end
endmodule
bind synth_mod_band_status_regs synth_regs_checker #(.BAND_W(BAND_W)) chk_i (.mclk, .rst_n,
   .chip_select_n, .lock_raw, .search_busy, .search_event, .search_band,
   .band_clock_divider_base, .output_power_code, .power_level_code, .modulator_order,
   .integer_mode, .band_in_use, .band_clock_divisor, .modband_readback, .flags_readback);
